// *** ctl_role.sv ***
// controller-role logic: becoming, holding and passing controller-in-charge
`timescale 1ns/100ps
`default_nettype none
module ctl_role
    import ctl_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic [3:0] aux_cmd,
    input  wire logic       aux_cmd_valid,
    input  wire logic [4:0] my_addr,
    input  wire logic       cmd_pass_en,
    input  wire logic       holdoff_on_end_bit,
    input  wire logic       holdoff_on_all_bit,
    input  wire logic [7:0] command_data_output_register,
    input  wire logic       command_data_output_register_write,
    input  wire logic       atn_line_n,
    input  wire logic [7:0] dio_line,
    input  wire logic       cmd_byte_accepted,
    input  wire logic       holdoff_active,
    input  wire logic       transfer_done,
    input  wire logic       byte_received,
    output logic            atn_out,
    output logic            ifc_out,
    output logic            ifc_ren_drive,
    output logic [7:0]      cmd_out_byte,
    output logic            cmd_out_valid,
    output logic            cic_flag,
    output logic            command_output_ready_flag,
    output logic            talker_addressed_flag,
    output logic            listener_addressed_flag,
    output logic            atn_inv_flag,
    output logic            pass_through_status_flag,
    output logic [7:0]      command_pass_through_register,
    output logic            continuous_mode,
    output logic            data_in_flag
);
    logic atn_bus_n;
    sync2 u_atn (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .d       (atn_line_n),
        .q       (atn_bus_n)
    );

    ctl_state_e st_reg, st_next;
    logic       atn_reg, atn_next;
    logic       ifc_reg, ifc_next;
    logic       drv_reg, drv_next;
    logic       cic_reg, cic_next;
    logic       co_reg, co_next;
    logic       ta_reg, ta_next;
    logic       la_reg, la_next;
    logic       tct_armed_reg, tct_armed_next;
    logic       tcse_reg, tcse_next;
    logic       tcs_req_reg, tcs_req_next;
    logic       cpt_reg, cpt_next;
    logic [7:0] command_pass_through_register_reg, command_pass_through_register_next;
    logic       cont_reg, cont_next;
    logic       di_reg, di_next;
    logic [7:0] cob_reg, cob_next;
    logic       cov_reg, cov_next;
    logic       pass_pend_reg, pass_pend_next;
    logic       rx_cmd;
    logic [7:0] own_talk;
    logic [7:0] own_listen;

    always_comb begin
        own_talk   = TALK_BASE | {3'h0, my_addr};
        own_listen = LISTEN_BASE | {3'h0, my_addr};
        rx_cmd     = byte_received && !atn_bus_n && !atn_reg;
    end

    always_comb begin
        st_next        = st_reg;
        atn_next       = atn_reg;
        ifc_next       = ifc_reg;
        drv_next       = drv_reg;
        cic_next       = cic_reg;
        co_next        = co_reg;
        ta_next        = ta_reg;
        la_next        = la_reg;
        tct_armed_next = tct_armed_reg;
        tcse_next      = tcse_reg;
        tcs_req_next   = tcs_req_reg;
        cpt_next       = cpt_reg;
        command_pass_through_register_next      = command_pass_through_register_reg;
        cont_next      = cont_reg || (holdoff_on_end_bit && holdoff_on_all_bit);
        di_next        = di_reg;
        cob_next       = cob_reg;
        cov_next       = 1'b0;
        pass_pend_next = pass_pend_reg;
        if (aux_cmd_valid) begin
            case (aux_cmd)
                CMD_SET_IFC: begin
                    ifc_next = 1'b1;
                    drv_next = 1'b1;
                    st_next  = CTL_WAIT_IFC;
                end
                CMD_CLR_IFC: ifc_next = 1'b0;
                CMD_DIS_SC: begin
                    drv_next = 1'b0;
                    ifc_next = 1'b0;
                end
                CMD_LON_CONT: cont_next = 1'b1;
                default: ;
            endcase
        end
        case (st_reg)
            CTL_IDLE: begin
                // armed by own talk then TCT
                if (tct_armed_reg && atn_bus_n) begin
                    st_next  = CTL_ACTIVE;
                    tct_armed_next = 1'b0;
                end
            end
            CTL_WAIT_IFC: begin
                cic_next = 1'b0;
                if (!ifc_reg) st_next = CTL_WAIT_ATN;
            end
            // wait for old controller to go idle
            CTL_WAIT_ATN: if (atn_bus_n) st_next = CTL_ACTIVE;
            CTL_ACTIVE: begin
                atn_next = 1'b1;
                if (!atn_reg) begin
                    cic_next = 1'b1;
                    co_next  = 1'b1;
                end
                if (command_data_output_register_write && co_reg) begin
                    cob_next = command_data_output_register;
                    cov_next = 1'b1;
                    co_next  = 1'b0;
                    if (command_data_output_register == own_listen) begin
                        la_next = 1'b1;
                        ta_next = 1'b0;
                    end else if (command_data_output_register == own_talk) begin
                        ta_next = 1'b1;
                        la_next = 1'b0;
                    end else if (command_data_output_register == UNLISTEN) begin
                        la_next = 1'b0;
                    end else if (command_data_output_register == UNTALK) begin
                        ta_next = 1'b0;
                    end
                    pass_pend_next = (command_data_output_register == BUS_TCT);
                end
                if (cmd_byte_accepted && cov_next == 1'b0 && !co_reg) co_next = 1'b1;
                // TCT accepted: release and go idle
                if (cmd_byte_accepted && pass_pend_reg) begin
                    atn_next       = 1'b0;
                    cic_next       = 1'b0;
                    co_next        = 1'b0;
                    pass_pend_next = 1'b0;
                    st_next        = CTL_IDLE;
                end
                if (aux_cmd_valid) begin
                    if (aux_cmd == CMD_LOC_LISTEN) begin
                        la_next = 1'b1;
                        ta_next = 1'b0;
                    end
                    if (aux_cmd == CMD_LOC_UNLSN) la_next = 1'b0;
                    if (aux_cmd == CMD_GTS) begin
                        atn_next = 1'b0;
                        co_next  = 1'b0;
                        st_next  = CTL_STANDBY;
                    end
                end
            end
            CTL_STANDBY: begin
                if (aux_cmd_valid && aux_cmd == CMD_TCSE) tcse_next = 1'b1;
                if (aux_cmd_valid && aux_cmd == CMD_TCS) tcs_req_next = 1'b1;
                if (aux_cmd_valid && aux_cmd == CMD_TCA) begin
                    st_next = CTL_ACTIVE;
                // retake on holdoff, sync at transfer end
                end else if ((tcse_reg && holdoff_active) ||
                             (tcs_req_reg && (transfer_done || holdoff_active))) begin
                    st_next = CTL_ACTIVE;
                end
                if (st_next == CTL_ACTIVE) begin
                    tcse_next    = 1'b0;
                    tcs_req_next = 1'b0;
                    atn_next     = 1'b1;
                    co_next      = 1'b1;
                end
            end
            default: st_next = CTL_IDLE;
        endcase
        if (rx_cmd) begin
            if (dio_line == own_talk) begin
                ta_next = 1'b1;
                la_next = 1'b0;
            end else if (dio_line == own_listen) begin
                la_next = 1'b1;
                ta_next = 1'b0;
            end else if (dio_line == UNTALK) begin
                ta_next = 1'b0;
            end else if (dio_line == UNLISTEN) begin
                la_next = 1'b0;
            end
            // TCT while talker-addressed hands control over
            if (dio_line == BUS_TCT && ta_reg) tct_armed_next = 1'b1;
            if (dio_line == BUS_TCT && cmd_pass_en) begin
                command_pass_through_register_next = dio_line;
                cpt_next  = 1'b1;
            end
        end
        // no data-in flag in continuous mode
        if (byte_received && atn_bus_n && la_reg && !cont_reg) di_next = 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_reg        <= CTL_IDLE;
            atn_reg       <= 1'b0;
            ifc_reg       <= 1'b0;
            drv_reg       <= 1'b0;
            cic_reg       <= 1'b0;
            co_reg        <= 1'b0;
            ta_reg        <= 1'b0;
            la_reg        <= 1'b0;
            tct_armed_reg <= 1'b0;
            tcse_reg      <= 1'b0;
            tcs_req_reg   <= 1'b0;
            cpt_reg       <= 1'b0;
            command_pass_through_register_reg      <= 8'h00;
            cont_reg      <= 1'b0;
            di_reg        <= 1'b0;
            cob_reg       <= 8'h00;
            cov_reg       <= 1'b0;
            pass_pend_reg <= 1'b0;
        end else begin
            st_reg        <= st_next;
            atn_reg       <= atn_next;
            ifc_reg       <= ifc_next;
            drv_reg       <= drv_next;
            cic_reg       <= cic_next;
            co_reg        <= co_next;
            ta_reg        <= ta_next;
            la_reg        <= la_next;
            tct_armed_reg <= tct_armed_next;
            tcse_reg      <= tcse_next;
            tcs_req_reg   <= tcs_req_next;
            cpt_reg       <= cpt_next;
            command_pass_through_register_reg      <= command_pass_through_register_next;
            cont_reg      <= cont_next;
            di_reg        <= di_next;
            cob_reg       <= cob_next;
            cov_reg       <= cov_next;
            pass_pend_reg <= pass_pend_next;
        end
    end

    assign atn_out                       = atn_reg;
    assign ifc_out                       = ifc_reg;
    assign ifc_ren_drive                 = drv_reg;
    assign cmd_out_byte                  = cob_reg;
    assign cmd_out_valid                 = cov_reg;
    assign cic_flag                      = cic_reg;
    assign command_output_ready_flag     = co_reg;
    assign talker_addressed_flag         = ta_reg;
    assign listener_addressed_flag       = la_reg;
    assign atn_inv_flag                  = atn_bus_n;
    assign pass_through_status_flag      = cpt_reg;
    assign command_pass_through_register = command_pass_through_register_reg;
    assign continuous_mode               = cont_reg;
    assign data_in_flag                  = di_reg;

    a_role_exclusive: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(ta_reg && la_reg)) else $error("talker and listener both set");
    a_standby_atn: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (st_reg == CTL_STANDBY) |-> (!atn_reg && cic_reg)) else $error("standby state wrong");
    a_drive_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (drv_reg && !(aux_cmd_valid && aux_cmd == CMD_DIS_SC)) |=> drv_reg)
        else $error("drivers dropped");
    a_ifc_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (aux_cmd_valid && aux_cmd == CMD_SET_IFC) |=> (drv_reg && ifc_reg))
        else $error("set ifc ignored");
    a_pass_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (st_reg == CTL_ACTIVE && pass_pend_reg && cmd_byte_accepted)
        |=> (!atn_reg && !cic_reg && st_reg == CTL_IDLE)) else $error("pass failed");
    a_cic_co: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (st_reg == CTL_ACTIVE && !atn_reg) |=> (cic_reg && co_reg)) else $error("cic not set");
    a_tca_now: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (st_reg == CTL_STANDBY && aux_cmd_valid && aux_cmd == CMD_TCA)
        |=> (st_reg == CTL_ACTIVE && atn_reg)) else $error("async take failed");
    a_ta_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (rx_cmd && dio_line == own_talk) |=> ta_reg) else $error("talk addr missed");
    a_cpt_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (rx_cmd && dio_line == BUS_TCT && cmd_pass_en) |=> (cpt_reg && command_pass_through_register_reg == BUS_TCT))
        else $error("pass-through missed");
endmodule
`default_nettype wire

// *** ctl_pkg.sv ***
// constants for the controller-role block
package ctl_pkg;
    localparam int unsigned CLK_MHZ       = 250;
    localparam int unsigned IFC_MIN_US    = 100;
    localparam int unsigned IFC_MIN_CYC   = IFC_MIN_US * CLK_MHZ;
    localparam logic [3:0] CMD_NONE       = 4'h0;
    localparam logic [3:0] CMD_SET_IFC    = 4'h1;
    localparam logic [3:0] CMD_CLR_IFC    = 4'h2;
    localparam logic [3:0] CMD_DIS_SC     = 4'h3;
    localparam logic [3:0] CMD_GTS        = 4'h4;
    localparam logic [3:0] CMD_TCA        = 4'h5;
    localparam logic [3:0] CMD_TCS        = 4'h6;
    localparam logic [3:0] CMD_TCSE       = 4'h7;
    localparam logic [3:0] CMD_LON_CONT   = 4'h8;
    localparam logic [3:0] CMD_LOC_LISTEN = 4'h9;
    localparam logic [3:0] CMD_LOC_UNLSN  = 4'ha;
    localparam logic [7:0] BUS_TCT        = 8'h09;
    localparam logic [7:0] TALK_BASE      = 8'h40;
    localparam logic [7:0] LISTEN_BASE    = 8'h20;
    localparam logic [7:0] UNLISTEN       = 8'h3f;
    localparam logic [7:0] UNTALK         = 8'h5f;
    localparam logic [4:0] ADDR_RESET     = 5'h00;
    typedef enum logic [2:0] {
        CTL_IDLE, CTL_WAIT_IFC, CTL_WAIT_ATN, CTL_ACTIVE, CTL_STANDBY, CTL_TCS_WAIT
    } ctl_state_e;
endpackage

// *** sync2.sv ***
// two-flop synchroniser for a bus line
`timescale 1ns/100ps
`default_nettype none
module sync2 (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic d,
    output logic      q
);
    logic s1_reg;
    logic s2_reg;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
        end
    end
    assign q = s2_reg;
endmodule
`default_nettype wire

// *** bus_peer.sv ***
// far-side model: the other controller and all listeners on the bus
`timescale 1ns/100ps
`default_nettype none
module bus_peer
    import ctl_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       atn_out,
    input  wire logic       ifc_out,
    input  wire logic [7:0] cmd_out_byte,
    input  wire logic       cmd_out_valid,
    input  wire logic [4:0] peer_addr,
    input  wire logic [1:0] accept_dly,
    output wire logic       atn_line_n,
    output logic [7:0]      dio_line,
    output logic            byte_received,
    output logic            cmd_byte_accepted
);
    logic       peer_atn = 1'b1;
    logic       peer_talk = 1'b0;
    logic [7:0] seen_b;
    // wired-or of both attention drivers, low true on the wire
    assign atn_line_n = ~(atn_out | peer_atn);
    initial begin
        dio_line = 8'h5a;
        byte_received = 1'b0;
        cmd_byte_accepted = 1'b0;
    end
    always @(posedge ifc_out) begin
        repeat (5) @(posedge clk_sys);
        #1 peer_atn = 1'b0;
    end
    // accept bytes, take attention on tct
    always @(posedge clk_sys) begin
        if (cmd_out_valid === 1'b1) begin
            seen_b = cmd_out_byte;
            if (seen_b === (TALK_BASE | {3'h0, peer_addr}))
                peer_talk = 1'b1;
            repeat (accept_dly) @(posedge clk_sys);
            #1 cmd_byte_accepted = 1'b1;
            @(posedge clk_sys);
            #1 cmd_byte_accepted = 1'b0;
            if (seen_b === BUS_TCT && peer_talk) begin
                peer_atn = 1'b1;
                peer_talk = 1'b0;
            end
        end
    end
    // one byte from the peer, line inverted once released
    task automatic send_cmd(input logic [7:0] b);
        dio_line = b;
        byte_received = 1'b1;
        @(posedge clk_sys);
        #1 byte_received = 1'b0;
        dio_line = ~b;
    endtask
    task automatic set_atn(input logic v);
        peer_atn = v;
    endtask
endmodule
`default_nettype wire

// *** ctl_role_tb_top.sv ***
// self-checking bench for the controller-role block
`timescale 1ns/100ps
`default_nettype none
module ctl_role_tb_top
    import ctl_pkg::*;
    ;
    localparam int ATN = 0, CIC = 1, DRV = 2, TAL = 3, LIS = 4, CONT = 5;
    localparam int PTS = 6, DIN = 7, COR = 8, IFC = 9, AINV = 10;
    logic       clk_sys = 1'b0;
    logic       rst_b = 1'b0;
    logic [3:0] aux_cmd = CMD_NONE;
    logic       aux_cmd_valid = 1'b0;
    logic [4:0] my_addr, peer_addr;
    logic       cmd_pass_en = 1'b0;
    logic       holdoff_on_end_bit = 1'b0;
    logic       holdoff_on_all_bit = 1'b0;
    logic [7:0] command_data_output_register = 8'h00;
    logic       command_data_output_register_write = 1'b0;
    logic       holdoff_active = 1'b0;
    logic       transfer_done = 1'b0;
    logic [1:0] accept_dly;
    logic [7:0] seed, exp_b;
    logic [7:0] exp_q[$];
    wire        atn_line_n, byte_received, cmd_byte_accepted;
    wire  [7:0] dio_line;
    logic       atn_out, ifc_out, ifc_ren_drive, cmd_out_valid, cic_flag;
    logic       command_output_ready_flag, talker_addressed_flag;
    logic       listener_addressed_flag, atn_inv_flag, pass_through_status_flag;
    logic       continuous_mode, data_in_flag;
    logic [7:0] cmd_out_byte, command_pass_through_register;
    int         error_cnt = 0;
    int         checks_done = 0;
    string      nm [11] = '{"atn_out", "cic_flag", "ifc_ren_drive", "talker", "listener",
                            "continuous", "pass_through", "data_in", "co", "ifc_out", "atn_inv"};
    wire  [10:0] obs = {atn_inv_flag, ifc_out, command_output_ready_flag, data_in_flag,
                        pass_through_status_flag, continuous_mode, listener_addressed_flag,
                        talker_addressed_flag, ifc_ren_drive, cic_flag, atn_out};

    always #2 clk_sys = ~clk_sys;

    ctl_role i_dut (
        .clk_sys, .rst_b, .aux_cmd, .aux_cmd_valid, .my_addr, .cmd_pass_en,
        .holdoff_on_end_bit, .holdoff_on_all_bit, .command_data_output_register,
        .command_data_output_register_write, .atn_line_n, .dio_line, .cmd_byte_accepted, .holdoff_active,
        .transfer_done, .byte_received, .atn_out, .ifc_out, .ifc_ren_drive,
        .cmd_out_byte, .cmd_out_valid, .cic_flag, .command_output_ready_flag,
        .talker_addressed_flag, .listener_addressed_flag, .atn_inv_flag,
        .pass_through_status_flag, .command_pass_through_register,
        .continuous_mode, .data_in_flag
    );
    bus_peer i_peer (
        .clk_sys, .atn_out, .ifc_out, .cmd_out_byte, .cmd_out_valid, .peer_addr,
        .accept_dly, .atn_line_n, .dio_line, .byte_received, .cmd_byte_accepted
    );

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // waits a bounded time for a flag to settle, then compares
    task automatic want(input int s, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && obs[s] !== v; i++)
            tick(1);
        chk(nm[s], {7'h0, v}, {7'h0, obs[s]});
    endtask
    task automatic aux(input logic [3:0] c);
        aux_cmd = c;
        aux_cmd_valid = 1'b1;
        tick(1);
        aux_cmd_valid = 1'b0;
        aux_cmd = CMD_NONE;
        tick(1);
    endtask
    task automatic put_cmd(input logic [7:0] b);
        int i;
        want(COR, 1'b1, 200);
        command_data_output_register = b;
        command_data_output_register_write = 1'b1;
        exp_q.push_back(b);
        tick(1);
        command_data_output_register_write = 1'b0;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (cmd_byte_accepted === 1'b1)
                break;
        end
        tick(3);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // each byte put on the bus is matched against the oldest note
    always @(posedge clk_sys) begin
        if (cmd_out_valid === 1'b1) begin
            exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            chk("cmd_out_byte", exp_b, cmd_out_byte);
        end
    end

    initial begin
        repeat (40000) @(posedge clk_sys);
        error_cnt++;
        $display("[ERR] watchdog expected finish seen hang");
        print_verdict();
    end

    initial begin
        seed = lfsr(8'h1f);
        my_addr = 5'(seed % 8'd30);
        peer_addr = my_addr + 5'd1;
        seed = lfsr(seed);
        accept_dly = seed[1:0];
        // a controller is present, so talk-only/listen-only stay off
        tick(16);
        rst_b = 1'b1;
        for (int s = 0; s < 10; s++) want(s, 1'b0, 0);
        aux(CMD_SET_IFC);
        want(IFC, 1'b1, 3);
        want(DRV, 1'b1, 3);
        tick(IFC_MIN_CYC);
        aux(CMD_CLR_IFC);
        want(IFC, 1'b0, 3);
        want(ATN, 1'b1, 20);
        want(CIC, 1'b1, 3);
        want(COR, 1'b1, 3);
        want(DRV, 1'b1, 0);
        $display("test seize done");
        put_cmd(LISTEN_BASE | {3'h0, my_addr});
        want(LIS, 1'b1, 5);
        put_cmd(TALK_BASE | {3'h0, my_addr});
        want(TAL, 1'b1, 5);
        want(LIS, 1'b0, 0);
        aux(CMD_LOC_LISTEN);
        want(LIS, 1'b1, 3);
        want(TAL, 1'b0, 0);
        aux(CMD_LOC_UNLSN);
        want(LIS, 1'b0, 3);
        $display("test addressing done");
        put_cmd(TALK_BASE | {3'h0, my_addr});
        aux(CMD_GTS);
        want(ATN, 1'b0, 2);
        want(CIC, 1'b1, 0);
        want(AINV, 1'b1, 6);
        want(TAL, 1'b1, 0);
        aux(CMD_TCA);
        want(ATN, 1'b1, 3);
        want(AINV, 1'b0, 6);
        put_cmd(LISTEN_BASE | {3'h0, my_addr});
        aux(CMD_GTS);
        want(ATN, 1'b0, 2);
        aux(CMD_TCS);
        tick(5);
        want(ATN, 1'b0, 0);
        transfer_done = 1'b1;
        tick(1);
        transfer_done = 1'b0;
        want(ATN, 1'b1, 5);
        $display("test standby done");
        put_cmd(UNLISTEN);
        want(LIS, 1'b0, 5);
        aux(CMD_LON_CONT);
        want(CONT, 1'b1, 3);
        // listener in standby, so a data byte would raise data-in outside continuous mode
        aux(CMD_LOC_LISTEN);
        want(LIS, 1'b1, 3);
        aux(CMD_GTS);
        want(ATN, 1'b0, 2);
        seed = lfsr(seed);
        i_peer.send_cmd(seed);
        tick(3);
        want(DIN, 1'b0, 0);
        aux(CMD_TCSE);
        tick(4);
        want(ATN, 1'b0, 0);
        holdoff_active = 1'b1;
        want(ATN, 1'b1, 5);
        holdoff_active = 1'b0;
        $display("test continuous done");
        put_cmd(TALK_BASE | {3'h0, peer_addr});
        put_cmd(BUS_TCT);
        want(ATN, 1'b0, 5);
        want(CIC, 1'b0, 5);
        cmd_pass_en = 1'b1;
        tick(3);
        i_peer.send_cmd(TALK_BASE | {3'h0, my_addr});
        want(TAL, 1'b1, 5);
        i_peer.send_cmd(BUS_TCT);
        want(PTS, 1'b1, 5);
        chk("command_pass_through_register", BUS_TCT, command_pass_through_register);
        tick(3);
        want(ATN, 1'b0, 0);
        i_peer.set_atn(1'b0);
        want(ATN, 1'b1, 10);
        want(CIC, 1'b1, 3);
        want(COR, 1'b1, 3);
        aux(CMD_DIS_SC);
        want(DRV, 1'b0, 3);
        $display("test hand-over done");
        rst_b = 1'b0;
        tick(2);
        rst_b = 1'b1;
        want(CONT, 1'b0, 0);
        holdoff_on_end_bit = 1'b1;
        tick(4);
        want(CONT, 1'b0, 0);
        holdoff_on_all_bit = 1'b1;
        want(CONT, 1'b1, 4);
        $display("test holdoff bits done");
        print_verdict();
    end
endmodule
`default_nettype wire
